/* File: core/can_vec_pkg.sv */
package can_vec_pkg;
    // ======================================================
    // register map, byte addresses
    localparam logic [7:0] ADDR_COUNT_CTRL = 8'h00;
    localparam logic [7:0] ADDR_VECTOR = 8'h04;
    localparam logic [7:0] ADDR_COUNT_SETUP = 8'h08;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_INT_MASK = 8'h10;
    // ======================================================
    // field layout
    localparam int COUNT_W = 5;
    localparam int HIT_W = 5;
    localparam int HIT_LSB = 8;
    localparam int CODE_W = 7;
    localparam int CODE_LSB = 0;
    localparam int NUM_BUF = 16;
    localparam int NUM_SRC = 20;
    localparam int SRC_ERR = 16;
    localparam int SRC_WAKE = 17;
    localparam int SRC_OVF = 18;
    localparam int SRC_FIFO = 19;
    localparam int EID_BITS = 18;
    localparam int PAYLOAD_W = 24;
    // ======================================================
    // values
    localparam logic [4:0] COUNT_MAX = 5'h11;
    localparam logic [4:0] COUNT_RESET = 5'h00;
    localparam logic [4:0] HIT_RESET = 5'h00;
    localparam logic [19:0] MASK_RESET = 20'h00000;
    localparam logic [19:0] STATUS_RESET = 20'h00000;
    localparam logic [6:0] CODE_NONE = 7'h40;
    localparam logic [6:0] CODE_ERR = 7'h41;
    localparam logic [6:0] CODE_WAKE = 7'h42;
    localparam logic [6:0] CODE_OVF = 7'h43;
    localparam logic [6:0] CODE_FIFO = 7'h44;
endpackage : can_vec_pkg

/* File: core/int_code_encoder.sv */
`timescale 1ns/100ps
module int_code_encoder
    import can_vec_pkg::*;
(
    input wire logic [19:0] pending,
    output logic [6:0] code
);
    // fixed priority: error, wake-up, overflow, fifo, then lowest buffer
    always_comb
    begin
        code = CODE_NONE;
        for (int i = NUM_BUF - 1; i >= 0; i--)
        begin
            if (pending[i])
            begin
                code = 7'(i);
            end
        end
        if (pending[SRC_FIFO])
        begin
            code = CODE_FIFO;
        end
        if (pending[SRC_OVF])
        begin
            code = CODE_OVF;
        end
        if (pending[SRC_WAKE])
        begin
            code = CODE_WAKE;
        end
        if (pending[SRC_ERR])
        begin
            code = CODE_ERR;
        end
    end
endmodule : int_code_encoder

/* File: core/payload_bit_compare.sv */
`timescale 1ns/100ps
module payload_bit_compare
    import can_vec_pkg::*;
(
    input wire logic [4:0] bitCount,
    input wire logic [23:0] payload,
    input wire logic [17:0] eid,
    output logic match
);
    logic [17:0] enable;
    logic [17:0] differ;
    // payload bit i is byte (1 + i/8), bit (7 - i%8): msb-first walk
    genvar i;
    generate
        for (i = 0; i < EID_BITS; i++)
        begin : g_bit
            assign enable[i] = (5'(i) < bitCount)
                || ((bitCount == COUNT_MAX) && (i == 17));
            assign differ[i] = enable[i] && (payload[PAYLOAD_W - 1 - i] != eid[i]);
        end
    endgenerate
    assign match = ~|differ;
endmodule : payload_bit_compare

/* File: core/can_filter_hit_interrupt_vector.sv */
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
// Notes on behaviour
// - count field 5 bits read-only; zero means no payload bits compared
// - count one compares first byte bit 7 with eid bit 0, each more adds one, count 17 adds two
// - largest count 17 compares up to byte 3 bit 6 against eid bit 17
// - counts 18 to 31 invalid; software must not pick them
// - control register bits above the count read zero
// - code bits 6..0 reset to no-interrupt, shown when nothing pending; others zero
// - error, wake-up, overflow, fifo almost full have own codes; higher codes never made
// - codes 0..15 name the pending buffer, code equals buffer number
module can_filter_hit_interrupt_vector
    import can_vec_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    input wire logic [15:0] bufferEvent,
    input wire logic errorEvent,
    input wire logic wakeEvent,
    input wire logic overflowEvent,
    input wire logic fifoFullEvent,
    input wire logic filterHitValid,
    input wire logic [4:0] filterHitNum,
    input wire logic [23:0] rxPayload,
    input wire logic [17:0] rxEid,
    output logic payloadMatch,
    output logic [6:0] interruptSourceCode,
    output logic irq
);
    // ======================================================
    // state
    logic [4:0] payloadFilterBitCount_reg;
    logic [4:0] payloadFilterBitCount_next;
    logic [4:0] matchedFilterNumber_reg;
    logic [4:0] matchedFilterNumber_next;
    logic [19:0] intStatus_reg;
    logic [19:0] intStatus_next;
    logic [19:0] intMask_reg;
    logic [19:0] intMask_next;
    logic [6:0] intCode_reg;
    logic [6:0] intCode_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic match_reg;
    logic match_next;
    logic [19:0] events;
    logic [19:0] pending;
    logic [6:0] encCode;
    logic matchComb;

    assign events = {fifoFullEvent, overflowEvent, wakeEvent, errorEvent, bufferEvent};
    // code and interrupt only look at unmasked sources
    assign pending = intStatus_reg & intMask_reg;

    int_code_encoder u_encoder (
        .pending(pending),
        .code(encCode)
    );

    payload_bit_compare u_compare (
        .bitCount(payloadFilterBitCount_reg),
        .payload(rxPayload),
        .eid(rxEid),
        .match(matchComb)
    );

    // ======================================================
    // next-state logic
    always_comb
    begin
        payloadFilterBitCount_next = payloadFilterBitCount_reg;
        matchedFilterNumber_next = matchedFilterNumber_reg;
        intMask_next = intMask_reg;
        intStatus_next = intStatus_reg;
        // invalid counts are dropped so the filter never sees them
        if (regWrite && (regAddr == ADDR_COUNT_SETUP) && (regWdata[4:0] <= COUNT_MAX))
        begin
            payloadFilterBitCount_next = regWdata[4:0];
        end
        if (regWrite && (regAddr == ADDR_INT_MASK))
        begin
            intMask_next = regWdata[19:0];
        end
        if (regWrite && (regAddr == ADDR_INT_STATUS))
        begin
            intStatus_next = intStatus_reg & ~regWdata[19:0];
        end
        // set after clear so a same-cycle event survives
        intStatus_next = intStatus_next | events;
        if (filterHitValid)
        begin
            matchedFilterNumber_next = filterHitNum;
        end
        intCode_next = encCode;
        match_next = matchComb;
        rdata_next = 32'h00000000;
        if (regRead)
        begin
            case (regAddr)
                ADDR_COUNT_CTRL, ADDR_COUNT_SETUP:
                begin
                    rdata_next[COUNT_W - 1:0] = payloadFilterBitCount_reg;
                end
                ADDR_VECTOR:
                begin
                    rdata_next[HIT_LSB + HIT_W - 1:HIT_LSB] = matchedFilterNumber_reg;
                    rdata_next[CODE_LSB + CODE_W - 1:CODE_LSB] = intCode_reg;
                end
                ADDR_INT_STATUS:
                begin
                    rdata_next[NUM_SRC - 1:0] = intStatus_reg;
                end
                ADDR_INT_MASK:
                begin
                    rdata_next[NUM_SRC - 1:0] = intMask_reg;
                end
                default:
                begin
                    rdata_next = 32'h00000000;
                end
            endcase
        end
    end

    // ======================================================
    // registers
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            payloadFilterBitCount_reg <= COUNT_RESET;
            matchedFilterNumber_reg <= HIT_RESET;
            intStatus_reg <= STATUS_RESET;
            intMask_reg <= MASK_RESET;
            intCode_reg <= CODE_NONE;
            rdata_reg <= 32'h00000000;
            match_reg <= 1'b1;
        end
        else
        begin
            payloadFilterBitCount_reg <= payloadFilterBitCount_next;
            matchedFilterNumber_reg <= matchedFilterNumber_next;
            intStatus_reg <= intStatus_next;
            intMask_reg <= intMask_next;
            intCode_reg <= intCode_next;
            rdata_reg <= rdata_next;
            match_reg <= match_next;
        end
    end

    assign regRdata = rdata_reg;
    assign interruptSourceCode = intCode_reg;
    assign payloadMatch = match_reg;
    assign irq = |pending;

    // ======================================================
    // checks
    a_count_zero_match: assert property (@(posedge mclk) disable iff (sys_rst)
        (payloadFilterBitCount_reg == 5'h00) |=> payloadMatch)
        else $error("zero count did not match");

    a_count_one_bit: assert property (@(posedge mclk) disable iff (sys_rst)
        (payloadFilterBitCount_reg == 5'h01) && (rxPayload[23] != rxEid[0]) |=> !payloadMatch)
        else $error("first payload bit not compared");

    a_count_top_bit: assert property (@(posedge mclk) disable iff (sys_rst)
        (payloadFilterBitCount_reg == COUNT_MAX) && (rxPayload[6] != rxEid[17])
        |=> !payloadMatch)
        else $error("byte 3 bit 6 not compared");

    a_count_valid: assert property (@(posedge mclk) disable iff (sys_rst)
        regWrite && (regAddr == ADDR_COUNT_SETUP) && (regWdata[4:0] > COUNT_MAX)
        |=> $stable(payloadFilterBitCount_reg))
        else $error("invalid count accepted");

    a_ctrl_upper_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        regRead && (regAddr == ADDR_COUNT_CTRL)
        |=> (regRdata[31:5] == 27'h0000000)
        && (regRdata[4:0] == $past(payloadFilterBitCount_reg)))
        else $error("count register read wrong");

    a_hit_capture: assert property (@(posedge mclk) disable iff (sys_rst)
        filterHitValid ##1 (regRead && (regAddr == ADDR_VECTOR) && !filterHitValid)
        |=> regRdata[12:8] == $past(filterHitNum, 2))
        else $error("filter hit number lost");

    a_vector_reserved: assert property (@(posedge mclk) disable iff (sys_rst)
        regRead && (regAddr == ADDR_VECTOR)
        |=> (regRdata[31:13] == 19'h00000) && !regRdata[7])
        else $error("vector reserved bits set");

    a_no_irq_code: assert property (@(posedge mclk) disable iff (sys_rst)
        (pending == 20'h00000) |=> (interruptSourceCode == CODE_NONE) && !$past(irq))
        else $error("code not idle with nothing pending");

    a_code_range: assert property (@(posedge mclk) disable iff (sys_rst)
        (interruptSourceCode <= 7'h0F) || ((interruptSourceCode >= CODE_NONE)
        && (interruptSourceCode <= CODE_FIFO)))
        else $error("reserved code produced");

    a_buffer_code: assert property (@(posedge mclk) disable iff (sys_rst)
        (pending[19:16] == 4'h0) && pending[9] && (pending[8:0] == 9'h000)
        |=> interruptSourceCode == 7'h09)
        else $error("buffer 9 code wrong");

    a_overflow_code: assert property (@(posedge mclk) disable iff (sys_rst)
        pending[SRC_OVF] && !pending[SRC_ERR] && !pending[SRC_WAKE]
        |=> interruptSourceCode == CODE_OVF)
        else $error("overflow code wrong");

    a_error_first: assert property (@(posedge mclk) disable iff (sys_rst)
        pending[SRC_ERR] |=> interruptSourceCode == CODE_ERR)
        else $error("error not highest priority");

    // ======================================================
    // register and status checks
    a_count_write_load: assert property (@(posedge mclk) disable iff (sys_rst)
        regWrite && (regAddr == ADDR_COUNT_SETUP) && (regWdata[4:0] <= COUNT_MAX)
        |=> payloadFilterBitCount_reg == $past(regWdata[4:0]))
        else $error("valid count not loaded");

    a_count_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        !(regWrite && (regAddr == ADDR_COUNT_SETUP))
        |=> $stable(payloadFilterBitCount_reg))
        else $error("count changed without a setup write");

    a_count_in_range: assert property (@(posedge mclk) disable iff (sys_rst)
        payloadFilterBitCount_reg <= COUNT_MAX)
        else $error("count holds an invalid value");

    a_setup_upper_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        regRead && (regAddr == ADDR_COUNT_SETUP)
        |=> (regRdata[31:5] == 27'h0000000)
        && (regRdata[4:0] == $past(payloadFilterBitCount_reg)))
        else $error("count setup read wrong");

    a_hit_load: assert property (@(posedge mclk) disable iff (sys_rst)
        filterHitValid
        |=> matchedFilterNumber_reg == $past(filterHitNum))
        else $error("filter hit number not captured");

    a_hit_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        !filterHitValid
        |=> $stable(matchedFilterNumber_reg))
        else $error("filter hit number changed on its own");

    a_vector_hit_read: assert property (@(posedge mclk) disable iff (sys_rst)
        regRead && (regAddr == ADDR_VECTOR)
        |=> regRdata[12:8] == $past(matchedFilterNumber_reg))
        else $error("vector read lost the hit number");

    a_vector_code_read: assert property (@(posedge mclk) disable iff (sys_rst)
        regRead && (regAddr == ADDR_VECTOR)
        |=> regRdata[6:0] == $past(interruptSourceCode))
        else $error("vector read lost the code");

    a_masked_code: assert property (@(posedge mclk) disable iff (sys_rst)
        (intStatus_reg != 20'h00000) && (pending == 20'h00000)
        |=> interruptSourceCode == CODE_NONE)
        else $error("masked source reached the code");

    a_irq_code_agree: assert property (@(posedge mclk) disable iff (sys_rst)
        irq
        |=> interruptSourceCode != CODE_NONE)
        else $error("interrupt raised with idle code");

    a_wake_code: assert property (@(posedge mclk) disable iff (sys_rst)
        pending[SRC_WAKE] && !pending[SRC_ERR]
        |=> interruptSourceCode == CODE_WAKE)
        else $error("wake-up code wrong");

    a_fifo_code: assert property (@(posedge mclk) disable iff (sys_rst)
        pending[SRC_FIFO] && (pending[SRC_OVF:SRC_ERR] == 3'h0)
        |=> interruptSourceCode == CODE_FIFO)
        else $error("fifo almost full code wrong");

    a_buffer_zero_code: assert property (@(posedge mclk) disable iff (sys_rst)
        pending[0] && (pending[19:16] == 4'h0)
        |=> interruptSourceCode == 7'h00)
        else $error("buffer 0 code wrong");

    a_buffer_order: assert property (@(posedge mclk) disable iff (sys_rst)
        pending[3] && (pending[2:0] == 3'h0) && (pending[19:16] == 4'h0)
        |=> interruptSourceCode == 7'h03)
        else $error("lower buffer not chosen first");

    a_status_set_wins: assert property (@(posedge mclk) disable iff (sys_rst)
        events != 20'h00000
        |=> (intStatus_reg & $past(events)) == $past(events))
        else $error("event lost against a clear");

    a_status_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        regWrite && (regAddr == ADDR_INT_STATUS) && (events == 20'h00000)
        |=> (intStatus_reg & $past(regWdata[19:0])) == 20'h00000)
        else $error("status bit not cleared by one");

    a_read_data_idle: assert property (@(posedge mclk) disable iff (sys_rst)
        !regRead
        |=> regRdata == 32'h00000000)
        else $error("read data outside its cycle");
endmodule : can_filter_hit_interrupt_vector

/* File: testbench/tb.sv */
`timescale 1ns/100ps
module tb
    import can_vec_pkg::*;
;
    logic mclk, sys_rst, regWrite, regRead, filterHitValid, payloadMatch, irq;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata, rd;
    logic [19:0] evt;
    logic [4:0] filterHitNum;
    logic [23:0] rxPayload;
    logic [17:0] rxEid;
    logic [6:0] interruptSourceCode;
    int errors, cmpCount;

    can_filter_hit_interrupt_vector i_dut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .bufferEvent(evt[15:0]), .errorEvent(evt[16]), .wakeEvent(evt[17]),
        .overflowEvent(evt[18]), .fifoFullEvent(evt[19]), .filterHitValid(filterHitValid),
        .filterHitNum(filterHitNum), .rxPayload(rxPayload), .rxEid(rxEid),
        .payloadMatch(payloadMatch), .interruptSourceCode(interruptSourceCode), .irq(irq));

    // ==========================================================
    // bus and compare helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask : reg_write

    // data stands only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask : reg_read

    task automatic pulse(input logic [19:0] v);
        @(posedge mclk);
        evt <= v;
        @(posedge mclk);
        evt <= 20'h00000;
        repeat (2) @(posedge mclk);
        #1;
    endtask : pulse

    // ==========================================================
    // scenarios
    task automatic reset_values();
        chk(interruptSourceCode, CODE_NONE);
        chk(irq, 1'b0);
        reg_read(ADDR_COUNT_CTRL, rd);
        chk(rd, 32'h00000000);
        reg_read(ADDR_VECTOR, rd);
        chk(rd, 32'h00000040);
        reg_read(8'h14, rd);
        chk(rd, 32'h00000000);
    endtask : reset_values

    task automatic count_limits();
        reg_write(ADDR_COUNT_SETUP, 32'h00000011);
        reg_write(ADDR_COUNT_SETUP, 32'h00000012);
        reg_write(ADDR_COUNT_SETUP, 32'h0000001F);
        reg_write(ADDR_COUNT_CTRL, 32'h00000003);
        reg_read(ADDR_COUNT_CTRL, rd);
        chk(rd, 32'h00000011);
        reg_write(ADDR_COUNT_SETUP, 32'hFFFFFFE1);
        reg_read(ADDR_COUNT_CTRL, rd);
        chk(rd, 32'h00000001);
        reg_read(ADDR_COUNT_SETUP, rd);
        chk(rd, 32'h00000001);
    endtask : count_limits

    task automatic match_at(input logic [23:0] p, input logic [17:0] e, input logic exp);
        @(posedge mclk);
        rxPayload <= p;
        rxEid <= e;
        @(posedge mclk);
        #1 chk(payloadMatch, exp);
    endtask : match_at

    // payload bit i sits at rxPayload[23-i]; count 17 takes 18 bits
    task automatic payload_case(input logic [4:0] cnt);
        int k;
        logic [17:0] e;
        logic [23:0] p;
        logic [23:0] q;
        k = (cnt == COUNT_MAX) ? 18 : int'(cnt);
        e = 18'h2A5C3;
        p = 24'h00002A;
        for (int i = 0; i < 18; i++)
            p[23 - i] = e[i];
        reg_write(ADDR_COUNT_SETUP, {27'h0000000, cnt});
        match_at(p, e, 1'b1);
        if (k > 0)
        begin
            q = p;
            q[24 - k] = ~q[24 - k];
            match_at(q, e, 1'b0);
        end
        if (k < 18)
        begin
            q = p;
            q[23 - k] = ~q[23 - k];
            match_at(q, e, 1'b1);
        end
    endtask : payload_case

    task automatic each_source();
        logic [6:0] c;
        reg_write(ADDR_INT_MASK, 32'h000FFFFF);
        for (int i = 0; i < NUM_SRC; i++)
        begin
            c = (i < NUM_BUF) ? 7'(i) : 7'(CODE_ERR + 7'(i - SRC_ERR));
            pulse(20'h00001 << i);
            chk(interruptSourceCode, c);
            chk(irq, 1'b1);
            reg_read(ADDR_VECTOR, rd);
            chk(rd[15:0], {9'h000, c});
            reg_read(ADDR_INT_STATUS, rd);
            chk(rd, 32'h00000001 << i);
            reg_write(ADDR_INT_STATUS, 32'h00000001 << i);
            repeat (2) @(posedge mclk);
            #1 chk(interruptSourceCode, CODE_NONE);
            chk(irq, 1'b0);
        end
    endtask : each_source

    task automatic priority_order();
        pulse(20'hA0208);
        chk(interruptSourceCode, CODE_WAKE);
        reg_write(ADDR_INT_STATUS, 32'h00020000);
        repeat (2) @(posedge mclk);
        #1 chk(interruptSourceCode, CODE_FIFO);
        reg_write(ADDR_INT_STATUS, 32'h00080000);
        repeat (2) @(posedge mclk);
        #1 chk(interruptSourceCode, 7'h03);
        reg_write(ADDR_INT_STATUS, 32'h00000008);
        repeat (2) @(posedge mclk);
        #1 chk(interruptSourceCode, 7'h09);
        reg_write(ADDR_INT_STATUS, 32'h00000200);
        repeat (2) @(posedge mclk);
        #1 chk(interruptSourceCode, CODE_NONE);
    endtask : priority_order

    // an event in the clearing cycle must survive the clear
    task automatic set_wins();
        @(posedge mclk);
        evt <= 20'h00004;
        regWrite <= 1'b1;
        regAddr <= ADDR_INT_STATUS;
        regWdata <= 32'h00000004;
        @(posedge mclk);
        evt <= 20'h00000;
        regWrite <= 1'b0;
        reg_read(ADDR_INT_STATUS, rd);
        chk(rd, 32'h00000004);
        reg_write(ADDR_INT_STATUS, 32'h00000004);
        reg_read(ADDR_INT_STATUS, rd);
        chk(rd, 32'h00000000);
    endtask : set_wins

    // masked source is recorded but stays silent
    task automatic masked_source();
        reg_write(ADDR_INT_MASK, 32'h000EFFFF);
        pulse(20'h10000);
        chk(irq, 1'b0);
        chk(interruptSourceCode, CODE_NONE);
        reg_read(ADDR_INT_STATUS, rd);
        chk(rd, 32'h00010000);
        reg_write(ADDR_INT_STATUS, 32'h00010000);
    endtask : masked_source

    // read issued in the cycle right after the hit, then again later
    task automatic filter_hit();
        @(posedge mclk);
        filterHitValid <= 1'b1;
        filterHitNum <= 5'h0A;
        @(posedge mclk);
        filterHitValid <= 1'b0;
        filterHitNum <= 5'h05;
        regRead <= 1'b1;
        regAddr <= ADDR_VECTOR;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 chk(regRdata, 32'h00000A40);
        @(posedge mclk);
        #1 chk(regRdata, 32'h00000000);
        reg_read(ADDR_VECTOR, rd);
        chk(rd, 32'h00000A40);
    endtask : filter_hit

    task automatic finish_test();
        if (errors == 0 && cmpCount > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // ==========================================================
    // clock, reset, sequence
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        errors++;
        finish_test();
    end

    initial
    begin
        errors = 0;
        cmpCount = 0;
        sys_rst = 1'b1;
        {regWrite, regRead, filterHitValid} = 3'h0;
        regAddr = 8'h00;
        regWdata = 32'h00000000;
        evt = 20'h00000;
        filterHitNum = 5'h00;
        rxPayload = 24'h000000;
        rxEid = 18'h00000;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        #1 reset_values();
        count_limits();
        for (int n = 0; n <= 17; n++)
            payload_case(5'(n));
        each_source();
        priority_order();
        set_wins();
        masked_source();
        filter_hit();
        finish_test();
    end
endmodule : tb
